//--- pkg/qsr_cfg.svh
// Constants for the quad setup register serial command block
`ifndef QSR_CFG_SVH
`define QSR_CFG_SVH

// ============================================================
// Clock and timing
`define QSR_CLK_PERIOD_NS 40
// Longest self-timed programming time, in ns (plain default)
`define QSR_CONFIG_WRITE_TIME_NS 1000000
// Longest time rounds down to whole cycles
`define QSR_CONFIG_WRITE_CYCLES (`QSR_CONFIG_WRITE_TIME_NS / `QSR_CLK_PERIOD_NS)

// ============================================================
// Opcodes and command sequence bytes
`define QSR_OP_READ_SETUP 8'h3f
`define QSR_SEQ_BYTE_1 8'h3d
`define QSR_SEQ_BYTE_2 8'h2a
`define QSR_SEQ_BYTE_3 8'h81
`define QSR_SEQ_ENABLE_4 8'h66
`define QSR_SEQ_DISABLE_4 8'h67

// ============================================================
// Register layout
`define QSR_QUAD_IO_ENABLE_POS 7
// Reserved field image: bits 6:4 zero, bit 3 one, bits 2:0 zero
`define QSR_RESERVED_FIELD_VAL 7'h08
`define QSR_SEQ_LAST_IDX 2'h3

`endif

//--- pkg/qsr_pkg.sv
// Types for the quad setup register serial command block
package qsr_pkg;

	// ============================================================
	// Command decoder states
	typedef enum logic [1:0] {
		ST_OPCODE,
		ST_READ,
		ST_SEQ,
		ST_IGNORE
	} qsr_state_e;

	typedef logic [7:0] qsr_byte_t;

endpackage : qsr_pkg

//--- hw/qsr_quad_setup.sv
// Serial command handling for the nonvolatile quad setup register
//
// Behaviour
// - After read opcode, device shifts out the setup register byte.
// - The same byte repeats while select stays low and clock toggles.
// - Raising select anywhere ends the read and floats the data output.
// - Register contents survive power cycles and resets.
// - Bit 7 is the quad enable bit; one enables quad, frees pin functions.
// - Reserved bits read fixed: 6:4 zero, 3 one, 2:0 zero.
// - Enable and disable sequences change only the top bit.
// - Quad enable set: quad commands recognised, pins become data lines 2, 3.
// - Quad enable clear: quad commands invalid, pins are plain control inputs.
// - Reset command leaves quad enable untouched; shipped value is zero.
// - Programming is self-timed within write time; status shows busy meanwhile.
// - Four-byte enable sequence programs quad enable to one.
// - Four-byte disable sequence programs quad enable to zero.
// - Programming starts only when select rises right after the fourth byte.
`timescale 1ns/1ps
`include "qsr_cfg.svh"

module qsr_quad_setup #(
	parameter int WRITE_CYCLES = `QSR_CONFIG_WRITE_CYCLES
) (
	// Clock, reset, enable
	input wire logic clk,
	input wire logic rst_n,
	input wire logic clk_en,
	// Serial pins from the host
	input wire logic spi_cs_n,
	input wire logic spi_sck,
	input wire logic spi_si,
	output logic spi_so,
	output logic spi_so_oe,
	// Multi-use pins, seen as control inputs when quad is off
	input wire logic wp_n_pin,
	input wire logic reset_n_pin,
	// Nonvolatile cell of the quad enable bit
	input wire logic nv_cell_q,
	output logic nv_prog_req,
	output logic nv_prog_data,
	// Status towards the rest of the device
	output logic quad_io_enable_bit,
	output logic quad_cmd_enable,
	output logic write_protect_active,
	output logic pin_reset_req,
	output logic ready_busy_flag
);

	// ============================================================
	// Pin synchronisers
	logic [1:0] cs_sync;
	logic [1:0] sck_sync;
	logic [1:0] si_sync;
	logic [1:0] wp_sync;
	logic [1:0] rstpin_sync;
	logic sck_prev;
	logic cs_prev;

	// Two flops per pin; only the second stage is read by logic
	// The serial clock needs three system clocks per half period to be seen
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cs_sync <= 2'h3;
			sck_sync <= 2'h0;
			si_sync <= 2'h0;
			wp_sync <= 2'h3;
			rstpin_sync <= 2'h3;
		end else if (clk_en) begin
			cs_sync <= {cs_sync[0], spi_cs_n};
			sck_sync <= {sck_sync[0], spi_sck};
			si_sync <= {si_sync[0], spi_si};
			wp_sync <= {wp_sync[0], wp_n_pin};
			rstpin_sync <= {rstpin_sync[0], reset_n_pin};
		end
	end

	// Delayed copies of the synchronised levels for edge finding
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			sck_prev <= 1'b0;
			cs_prev <= 1'b1;
		end else if (clk_en) begin
			sck_prev <= sck_sync[1];
			cs_prev <= cs_sync[1];
		end
	end

	logic cs_active;
	logic sck_rise;
	logic sck_fall;
	logic cs_release;

	// Edges only count while select is low
	// Release lasts one cycle, long enough to launch an armed update
	assign cs_active = !cs_sync[1];
	assign sck_rise = cs_active && sck_sync[1] && !sck_prev;
	assign sck_fall = cs_active && !sck_sync[1] && sck_prev;
	assign cs_release = cs_sync[1] && !cs_prev;

	// ============================================================
	// Setup register image
	// Working copy of the quad enable bit; the cell is the real store
	logic quad_stored;
	logic nv_loaded;
	logic busy;
	logic [$clog2(WRITE_CYCLES + 1) - 1:0] prog_cnt;
	logic prog_target;
	qsr_pkg::qsr_byte_t setup_byte;

	// Reserved bits are constants, only the top bit is stored
	assign setup_byte = {quad_stored, `QSR_RESERVED_FIELD_VAL};

	// ============================================================
	// Command decoder
	qsr_pkg::qsr_state_e state;
	logic [2:0] bit_cnt;
	logic [6:0] in_shift;
	logic [1:0] seq_idx;
	logic seq_armed;
	logic seq_value;
	qsr_pkg::qsr_byte_t in_byte;
	logic byte_done;

	// The newest bit joins the shifter in the same cycle it is sampled
	assign in_byte = {in_shift, si_sync[1]};
	assign byte_done = sck_rise && (bit_cnt == 3'h7);

	// Input shifter, MSB first; counter restarts on every select
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			bit_cnt <= 3'h0;
			in_shift <= 7'h00;
		end else if (clk_en) begin
			if (!cs_active) begin
				bit_cnt <= 3'h0;
			end else if (sck_rise) begin
				bit_cnt <= bit_cnt + 3'h1;
				in_shift <= in_byte[6:0];
			end
		end
	end

	// Byte-level state; any deviation from a sequence falls to ignore
	// Nothing carries over between frames, so a sequence cannot span two selects
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state <= qsr_pkg::ST_OPCODE;
			seq_idx <= 2'h0;
			seq_armed <= 1'b0;
			seq_value <= 1'b0;
		end else if (clk_en) begin
			if (!cs_active) begin
				state <= qsr_pkg::ST_OPCODE;
				seq_idx <= 2'h0;
				if (!cs_release) begin
					seq_armed <= 1'b0;
				end
			end else if (sck_rise && seq_armed) begin
				// Extra bits after the fourth byte cancel the update
				seq_armed <= 1'b0;
				state <= qsr_pkg::ST_IGNORE;
			end else if (byte_done) begin
				case (state)
					qsr_pkg::ST_OPCODE: begin
						if (in_byte == `QSR_OP_READ_SETUP) begin
							state <= qsr_pkg::ST_READ;
						end else if (in_byte == `QSR_SEQ_BYTE_1) begin
							state <= qsr_pkg::ST_SEQ;
							seq_idx <= 2'h1;
						end else begin
							state <= qsr_pkg::ST_IGNORE;
						end
					end
					qsr_pkg::ST_SEQ: begin
						if (seq_idx == 2'h1 && in_byte == `QSR_SEQ_BYTE_2) begin
							seq_idx <= 2'h2;
						end else if (seq_idx == 2'h2 && in_byte == `QSR_SEQ_BYTE_3) begin
							seq_idx <= `QSR_SEQ_LAST_IDX;
						end else if (seq_idx == `QSR_SEQ_LAST_IDX
								&& in_byte == `QSR_SEQ_ENABLE_4) begin
							seq_armed <= 1'b1;
							seq_value <= 1'b1;
							state <= qsr_pkg::ST_IGNORE;
						end else if (seq_idx == `QSR_SEQ_LAST_IDX
								&& in_byte == `QSR_SEQ_DISABLE_4) begin
							seq_armed <= 1'b1;
							seq_value <= 1'b0;
							state <= qsr_pkg::ST_IGNORE;
						end else begin
							state <= qsr_pkg::ST_IGNORE;
						end
					end
					qsr_pkg::ST_READ: begin
						state <= qsr_pkg::ST_READ;
					end
					qsr_pkg::ST_IGNORE: begin
						state <= qsr_pkg::ST_IGNORE;
					end
					default: begin
						state <= qsr_pkg::ST_IGNORE;
					end
				endcase
			end
		end
	end

	// ============================================================
	// Serial output
	logic [2:0] out_idx;

	// Bits change on falling clock, so the first bit is set up
	// before the host's next rising edge; the index wraps to repeat
	// The data level is left as is when released; only the enable floats it
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			spi_so <= 1'b0;
			spi_so_oe <= 1'b0;
			out_idx <= 3'h7;
		end else if (clk_en) begin
			if (!cs_active) begin
				spi_so_oe <= 1'b0;
				out_idx <= 3'h7;
			end else if (sck_fall && state == qsr_pkg::ST_READ) begin
				spi_so <= setup_byte[out_idx];
				spi_so_oe <= 1'b1;
				out_idx <= out_idx - 3'h1;
			end
		end
	end

	// ============================================================
	// Self-timed programming
	// The stored bit comes from the nonvolatile cell after every reset,
	// so neither a reset nor a power cycle can disturb it
	// Hazard: a reset in mid-programming leaves the cell to decide the value;
	// the copy only follows the target once the full count has run
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			quad_stored <= 1'b0;
			nv_loaded <= 1'b0;
		end else if (clk_en) begin
			if (!nv_loaded) begin
				quad_stored <= nv_cell_q;
				nv_loaded <= 1'b1;
			end else if (busy && prog_cnt == '0) begin
				quad_stored <= prog_target;
			end
		end
	end

	// Start on select release straight after the fourth byte
	// Sequences seen while busy or before the cell is loaded are dropped
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			busy <= 1'b0;
			prog_cnt <= '0;
			prog_target <= 1'b0;
			nv_prog_req <= 1'b0;
			nv_prog_data <= 1'b0;
		end else if (clk_en) begin
			nv_prog_req <= 1'b0;
			if (!busy && nv_loaded && cs_release && seq_armed && bit_cnt == 3'h0) begin
				busy <= 1'b1;
				prog_cnt <= ($bits(prog_cnt))'(WRITE_CYCLES - 1);
				prog_target <= seq_value;
				nv_prog_req <= 1'b1;
				nv_prog_data <= seq_value;
			end else if (busy) begin
				if (prog_cnt == '0) begin
					busy <= 1'b0;
				end else begin
					prog_cnt <= prog_cnt - 1'b1;
				end
			end
		end
	end

	// ============================================================
	// Quad mode and pin functions
	// Pin functions are masked while quad mode owns the pins
	// One cycle of lag behind the bit keeps every output a flop
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			quad_io_enable_bit <= 1'b0;
			quad_cmd_enable <= 1'b0;
			write_protect_active <= 1'b0;
			pin_reset_req <= 1'b0;
			ready_busy_flag <= 1'b0;
		end else if (clk_en) begin
			quad_io_enable_bit <= quad_stored;
			quad_cmd_enable <= quad_stored;
			write_protect_active <= !quad_stored && !wp_sync[1];
			pin_reset_req <= !quad_stored && !rstpin_sync[1];
			ready_busy_flag <= nv_loaded && !busy;
		end
	end

endmodule : qsr_quad_setup

//--- dv/qsr_quad_setup_checker.sv
// Port assertions for the quad setup register block
`timescale 1ns/1ps
module qsr_quad_setup_checker (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Watched ports
	input wire logic spi_cs_n,
	input wire logic spi_so_oe,
	input wire logic nv_prog_req,
	input wire logic quad_io_enable_bit,
	input wire logic quad_cmd_enable,
	input wire logic write_protect_active,
	input wire logic pin_reset_req,
	input wire logic ready_busy_flag
);
	// ============================================================
	// Relations between ports, one clock domain
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_n);
	prog_pulse_a: assert property (nv_prog_req |=> !nv_prog_req) else $error("long pulse");
	busy_prog_a: assert property (nv_prog_req |=> !ready_busy_flag[*8])
		else $error("no busy");
	prog_idle_a: assert property (nv_prog_req |-> $past(ready_busy_flag))
		else $error("prog busy");
	// Sync plus register delay, two spare edges
	oe_drop_a: assert property (spi_cs_n[*6] |-> !spi_so_oe) else $error("so held");
	qe_change_a: assert property ($changed(quad_io_enable_bit) |-> $rose(ready_busy_flag))
		else $error("qe moved");
	cmd_follow_a: assert property (quad_io_enable_bit && $past(quad_io_enable_bit)
		|-> quad_cmd_enable) else $error("cmd off");
	wp_mask_a: assert property (quad_io_enable_bit && $past(quad_io_enable_bit)
		|-> !write_protect_active) else $error("wp on");
	rst_mask_a: assert property (quad_io_enable_bit && $past(quad_io_enable_bit)
		|-> !pin_reset_req) else $error("reset on");
endmodule : qsr_quad_setup_checker

//--- dv/qsr_host_model.sv
// Host serial controller model, mode 0, clock still between frames
`timescale 1ns/1ps
module qsr_host_model (
	// Clock
	input wire logic clk,
	// Serial pins
	output logic cs_n,
	output logic sck,
	output logic si,
	input wire logic so,
	input wire logic so_oe
);
	logic [7:0] rx;
	initial begin
		cs_n = 1'b1;
		sck = 1'b0;
		si = 1'b0;
		rx = 8'h00;
	end
	// Half of a 320 ns serial period
	task automatic half();
		repeat (4) @(negedge clk);
	endtask : half
	// MSB first, change on low, sample late in high phase
	task automatic xbits(input logic [7:0] tx, input int n);
		for (int i = 7; i > 7 - n; i--) begin
			si = tx[i];
			half();
			sck = 1'b1;
			half();
			rx[i] = so_oe ? so : ~rx[i];
			sck = 1'b0;
		end
	endtask : xbits
	task automatic start();
		cs_n = 1'b0;
		half();
	endtask : start
	// Released data line must not look held
	task automatic stop();
		half();
		cs_n = 1'b1;
		si = ~si;
		repeat (2) half();
	endtask : stop
endmodule : qsr_host_model

//--- dv/qsr_quad_setup_bench.sv
// Self-checking bench for the quad setup register block
`timescale 1ns/1ps
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin fails++; \
	$display("[FAIL] %0t got %h exp %h", $time, a, b); end end
module qsr_quad_setup_bench;
	logic clk, rst_n, cs_n, sck, si, so, so_oe, wp_n, rp_n, nv_q, preq, pdat;
	logic qbit, qcmd, wpa, prr, rdy;
	logic [7:0] obs, ex;
	logic [7:0] expq[$];
	int fails, cmp_count, seed;
	event got;
	qsr_quad_setup #(.WRITE_CYCLES(20)) dut (.clk(clk), .rst_n(rst_n), .clk_en(1'b1),
		.spi_cs_n(cs_n), .spi_sck(sck), .spi_si(si), .spi_so(so), .spi_so_oe(so_oe),
		.wp_n_pin(wp_n), .reset_n_pin(rp_n), .nv_cell_q(nv_q), .nv_prog_req(preq),
		.nv_prog_data(pdat), .quad_io_enable_bit(qbit), .quad_cmd_enable(qcmd),
		.write_protect_active(wpa), .pin_reset_req(prr), .ready_busy_flag(rdy));
	qsr_host_model host (.clk(clk), .cs_n(cs_n), .sck(sck), .si(si), .so(so), .so_oe(so_oe));
	// Nonvolatile cell keeps the programmed value across resets; shipped as zero
	initial begin
		nv_q = 1'b0;
		forever @(posedge clk) if (preq) nv_q <= pdat;
	end
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	// Oldest note against each observed result
	always @(got) begin
		ex = expq.pop_front();
		`CHK(obs, ex)
	end
	task automatic check(input logic [7:0] e, input logic [7:0] v);
		expq.push_back(e);
		obs = v;
		->got;
		@(negedge clk);
	endtask : check
	// Poll the busy flag with a bound
	task automatic wait_rdy();
		int n = 0;
		while (rdy !== 1'b1 && n < 300) begin
			@(negedge clk);
			n++;
		end
		if (n >= 300) `CHK(rdy, 1'b1)
	endtask : wait_rdy
	// Two bytes, the first may be stale at high clock rates
	task automatic rd_cfg(input logic [7:0] e);
		wait_rdy();
		host.start();
		host.xbits(8'h3f, 8);
		repeat (2) begin
			host.xbits(8'h00, 8);
			check(e, host.rx);
		end
		host.stop();
	endtask : rd_cfg
	// An extra byte after the fourth must cancel the update
	task automatic cmd4(input logic [7:0] b4, input bit extra);
		host.start();
		host.xbits(8'h3d, 8);
		host.xbits(8'h2a, 8);
		host.xbits(8'h81, 8);
		host.xbits(b4, 8);
		if (extra) host.xbits(8'h00, 8);
		host.stop();
		check({7'h00, extra}, {7'h00, rdy});
		if (!extra) check({7'h00, b4 == 8'h66}, {7'h00, pdat});
		wait_rdy();
	endtask : cmd4
	task automatic pins(input logic q);
		repeat (4) begin
			{wp_n, rp_n} = 2'($random(seed));
			repeat (5) @(negedge clk);
			check({6'h00, ~q & ~wp_n, ~q & ~rp_n}, {6'h00, wpa, prr});
			check({6'h00, q, q}, {6'h00, qbit, qcmd});
		end
	endtask : pins
	task automatic complete_run();
		$display("compares %0d mismatches %0d", cmp_count, fails);
		if (fails == 0 && cmp_count > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask : complete_run
	initial begin
		seed = 82;
		{rst_n, wp_n, rp_n} = 3'b011;
		repeat (20) @(negedge clk);
		rst_n = 1'b1;
		rd_cfg(8'h08);
		pins(1'b0);
		$display("shipped state done");
		cmd4(8'h66, 1'b0);
		rd_cfg(8'h88);
		pins(1'b1);
		cmd4(8'h67, 1'b1);
		rd_cfg(8'h88);
		$display("enable done");
		// Select raised in mid-byte
		host.start();
		host.xbits(8'h3f, 8);
		host.xbits(8'h00, 3);
		host.stop();
		check(8'h00, {7'h00, so_oe});
		rst_n = 1'b0;
		repeat (2) @(negedge clk);
		rst_n = 1'b1;
		rd_cfg(8'h88);
		cmd4(8'h67, 1'b0);
		rd_cfg(8'h08);
		$display("disable done");
		complete_run();
	end
	initial begin
		#2000000;
		fails++;
		complete_run();
	end
endmodule : qsr_quad_setup_bench
bind qsr_quad_setup qsr_quad_setup_checker chk (.clk(clk), .rst_n(rst_n),
	.spi_cs_n(spi_cs_n), .spi_so_oe(spi_so_oe), .nv_prog_req(nv_prog_req),
	.quad_io_enable_bit(quad_io_enable_bit), .quad_cmd_enable(quad_cmd_enable),
	.write_protect_active(write_protect_active), .pin_reset_req(pin_reset_req),
	.ready_busy_flag(ready_busy_flag));
